/* shared/supervision_regs_pkg.sv */
// Purpose: Shared constants and carriers for the primary supervision
//          register bank.
// Assumes: 16-bit register words, 7-bit register index on the request port.
// Notes:   Offsets are register indices as seen on the serial frame.
package supervision_regs_pkg;

    localparam logic [6:0]  offset_supervision_select   = 7'h08;
    localparam logic [6:0]  offset_scratch_value        = 7'h09;
    localparam logic [6:0]  offset_pin_level_snapshot   = 7'h0a;
    localparam logic [6:0]  offset_clock_check          = 7'h0b;

    localparam logic [15:0] reset_supervision_select    = 16'h0001;
    localparam logic [15:0] reset_scratch_value         = 16'h0001;
    localparam logic [15:0] reset_clock_check           = 16'h0001;

    localparam int          choice_lsb                  = 2;
    localparam int          choice_msb                  = 3;
    localparam int          scratch_lsb                 = 2;
    localparam int          scratch_msb                 = 15;
    localparam int          count_lsb                   = 8;
    localparam int          count_msb                   = 15;
    localparam int          rejected_bit                = 1;
    localparam int          parity_bit                  = 0;
    localparam int          pin_lsb                     = 2;
    localparam int          pin_msb                     = 8;

    localparam logic [1:0]  choice_none                 = 2'h0;
    localparam logic [1:0]  choice_reserved             = 2'h1;
    localparam logic [1:0]  choice_clock                = 2'h2;
    localparam logic [1:0]  choice_dio                  = 2'h3;

    typedef struct packed {
        logic       aux_io_level;
        logic       serial_out_level;
        logic       fault_two_level;
        logic       fault_one_level;
        logic       enable_pin_state;
        logic       inverting_cmd_level;
        logic       noninverting_cmd_level;
    } pin_levels_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] index;
        logic [15:0] data;
    } reg_request_s;

endpackage

/* tb/host_model.sv */
// Purpose: Host side that issues register requests.
// Assumes: The answer is on read_data right after the taken edge, read 1 ns later.
// Notes:   Idle index and data fields show the inverse of the last request; write is cleared.
`timescale 1ns/10ps
module host_model (
    input wire logic                          mclk,
    input wire logic [15:0]                   read_data,
    input wire logic                          read_valid,
    output supervision_regs_pkg::reg_request_s request
);
    initial request = '{1'b0, 1'b0, 7'h7f, 16'h0};
    task automatic access(input logic wr, input logic [6:0] ix,
        input logic [15:0] d, output logic [15:0] q, output logic ok);
        @(posedge mclk) #1;
        request = '{1'b1, wr, ix, d};
        @(posedge mclk) #1;
        request = '{1'b0, 1'b0, ~ix, ~d};
        q = read_data;
        ok = read_valid;
    endtask
endmodule

/* tb/regs_props.sv */
// Purpose: Port checks for the supervision register bank.
// Assumes: One answer per request, one cycle later.
// Notes:   Parity is odd over the whole returned word.
`timescale 1ns/10ps
module regs_props (
    input wire logic                               mclk,
    input wire logic                               rst,
    input wire supervision_regs_pkg::reg_request_s request,
    input wire logic                               frame_rejected,
    input wire logic                               frame_done,
    input wire supervision_regs_pkg::pin_levels_s  pins,
    input wire logic                               enter_verification,
    input wire logic                               clock_check_start,
    input wire logic                               dio_check_start,
    input wire logic [15:0]                        read_data,
    input wire logic                               read_valid
);
    logic rej;
    always_ff @(posedge mclk) begin
        rej <= rst ? 1'b0 : (frame_done ? frame_rejected : rej);
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_ans; request.valid |=> read_valid; endproperty
    a_ans: assert property (p_ans) else $error("missing answer");
    property p_quiet; !request.valid |=> !read_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_par; read_valid |-> ^read_data; endproperty
    a_par: assert property (p_par) else $error("even parity");
    property p_rej; read_valid |-> read_data[1] == $past(rej); endproperty
    a_rej: assert property (p_rej) else $error("bad flag");
    property p_sel;
        read_valid && $past(request.index) == 7'h08 |->
            read_data[15:4] == 12'h0;
    endproperty
    a_sel: assert property (p_sel) else $error("select high bits");
    property p_pin;
        read_valid && $past(request.index) == 7'h0a |->
            read_data[15:2] == {7'h0, $past(pins, 2)};
    endproperty
    a_pin: assert property (p_pin) else $error("pin word");
    property p_cnt;
        read_valid && $past(request.index) == 7'h0b |->
            read_data[7:2] == 6'h0;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count low bits");
    property p_start;
        clock_check_start || dio_check_start |-> $past(enter_verification);
    endproperty
    a_start: assert property (p_start) else $error("early start");
    property p_excl; !(clock_check_start && dio_check_start); endproperty
    a_excl: assert property (p_excl) else $error("both starts");
endmodule
bind primary_supervision_pin_status_regs regs_props i_props (
    .mclk(mclk), .rst(rst), .request(request),
    .frame_rejected(frame_rejected), .frame_done(frame_done),
    .pins(pins), .enter_verification(enter_verification),
    .clock_check_start(clock_check_start),
    .dio_check_start(dio_check_start),
    .read_data(read_data), .read_valid(read_valid));

/* tb/tb.sv */
// Purpose: Scenario bench for the supervision register bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Expected words are built from the field layout only.
`timescale 1ns/10ps
module tb;
    logic mclk, rst, frame_rejected, frame_done, enter_verification;
    logic enter_initial, clock_check_done, read_valid, ok;
    logic clock_check_start, dio_check_start;
    logic [7:0] clock_check_count;
    logic [15:0] read_data, q, sc;
    supervision_regs_pkg::reg_request_s request;
    supervision_regs_pkg::pin_levels_s pins;
    int err_count = 0;
    int checks = 0;
    int nc, nd;
    primary_supervision_pin_status_regs i_dut (.mclk(mclk), .rst(rst),
        .request(request), .frame_rejected(frame_rejected),
        .frame_done(frame_done), .pins(pins),
        .enter_verification(enter_verification),
        .enter_initial(enter_initial), .clock_check_done(clock_check_done),
        .clock_check_count(clock_check_count), .read_data(read_data),
        .read_valid(read_valid), .clock_check_start(clock_check_start),
        .dio_check_start(dio_check_start));
    host_model i_host (.mclk(mclk), .read_data(read_data),
        .read_valid(read_valid), .request(request));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    function automatic logic [15:0] w(input logic [15:1] b);
        return {b, ~^b};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xf(logic wr, logic [6:0] ix, logic [15:0] d,
        logic [15:0] e, string nm);
        i_host.access(wr, ix, d, q, ok);
        chk("answer", 16'h1, {15'h0, ok});
        chk(nm, e, q);
    endtask
    task automatic pulse(ref logic s);
        @(posedge mclk) #1 s = 1'b1;
        @(posedge mclk) #1 s = 1'b0;
    endtask
    task automatic t_select();
        for (int c = 0; c < 4; c++) begin
            xf(1'b1, 7'h08, {12'hfff, 2'(c), 2'h3}, 16'h1, "old");
            xf(1'b0, 7'h08, 16'h0, w({12'h0, 2'(c), 1'b0}), "choice");
            pulse(enter_verification);
            nc = 0;
            nd = 0;
            repeat (3) begin
                nc += int'(clock_check_start === 1'b1);
                nd += int'(dio_check_start === 1'b1);
                @(posedge mclk) #1;
            end
            chk("clk start", 16'(c == 2), 16'(nc));
            chk("dio start", 16'(c == 3), 16'(nd));
            pulse(enter_initial);
        end
        xf(1'b0, 7'h08, 16'h0, 16'h1, "cleared");
    endtask
    task automatic t_scratch();
        sc = 16'h1;
        xf(1'b1, 7'h09, 16'hfffd, sc, "scr old");
        sc = w({14'h3fff, 1'b0});
        xf(1'b0, 7'h09, 16'h0, sc, "scratch");
        xf(1'b1, 7'h09, 16'h5556, sc, "scr old");
        sc = w({14'h1555, 1'b0});
        xf(1'b0, 7'h09, 16'h0, sc, "scratch");
    endtask
    task automatic t_pins(logic [6:0] p);
        pins = p;
        xf(1'b1, 7'h0a, 16'hffff, w({7'h0, p, 1'b0}), "pin wr");
        xf(1'b0, 7'h0a, 16'h0, w({7'h0, p, 1'b0}), "pins");
    endtask
    task automatic t_reject();
        frame_rejected = 1'b1;
        pulse(frame_done);
        xf(1'b0, 7'h09, 16'h0, w({sc[15:2], 1'b1}), "rejected");
        xf(1'b0, 7'h0c, 16'h0, w(15'h1), "unmapped");
        frame_rejected = 1'b0;
        pulse(frame_done);
        xf(1'b0, 7'h09, 16'h0, sc, "accepted");
    endtask
    task automatic t_count();
        clock_check_count = 8'ha5;
        pulse(clock_check_done);
        xf(1'b1, 7'h0b, 16'hffff, w({8'ha5, 7'h0}), "cnt wr");
        xf(1'b0, 7'h0b, 16'h0, w({8'ha5, 7'h0}), "count");
    endtask
    task automatic summarize();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {rst, frame_rejected, frame_done, enter_verification} = 4'hf;
        {frame_rejected, frame_done, enter_verification} = 3'h0;
        {enter_initial, clock_check_done, clock_check_count} = 10'h0;
        pins = 7'h0;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        xf(1'b0, 7'h08, 16'h0, 16'h1, "reset");
        t_select();
        t_scratch();
        t_pins(7'h55);
        t_pins(7'h2a);
        t_reject();
        t_count();
        summarize();
    end
endmodule

/* verilog/odd_parity_word.sv */
// Purpose: Places the odd parity bit into bit 0 of a 16-bit read word.
// Assumes: Bit 0 of the input is ignored.
// Notes:   Purely combinational.
`timescale 1ns/10ps
module odd_parity_word (
    input  wire logic [15:0] raw_word,
    output logic      [15:0] sealed_word
);
    always_comb begin
        sealed_word    = raw_word;
        sealed_word[0] = ~^raw_word[15:1];
    end
endmodule

/* verilog/primary_supervision_pin_status_regs.sv */
// Purpose: Supervision select, scratch and pin snapshot registers.
// Assumes: Frames are decoded outside; one request pulse per accepted frame.
// Notes:   Read data is registered one cycle after the request.
`timescale 1ns/10ps

// How it works
// - Select field sits at bits 3:2.
// - Codes: none, reserved, clock, digital IO.
// - Selection starts only on verification mode entry.
// - Initial mode entry clears the select field.
// - Reserved bits always read as zero.
// - Bit 1 reports last frame rejected.
// - Bit 0 is odd parity over word.
// - Scratch bits 15:2 store, drive nothing.
// - Bit 8 shows aux IO level.
// - Bit 7 shows serial output level.
// - Bits 6,5 show fault two, one levels.
// - Bit 4 shows enable pin level.
// - Bits 3,2 show inverting, noninverting levels.
// - Clock check count lands in bits 15:8.
module primary_supervision_pin_status_regs (
    input  wire logic                               mclk,
    input  wire logic                               rst,
    input  wire supervision_regs_pkg::reg_request_s request,
    input  wire logic                               frame_rejected,
    input  wire logic                               frame_done,
    input  wire supervision_regs_pkg::pin_levels_s  pins,
    input  wire logic                               enter_verification,
    input  wire logic                               enter_initial,
    input  wire logic                               clock_check_done,
    input  wire logic [7:0]                         clock_check_count,
    output logic [15:0]                             read_data,
    output logic                                    read_valid,
    output logic                                    clock_check_start,
    output logic                                    dio_check_start
);

    typedef struct packed {
        logic [1:0]  verification_choice;
        logic [13:0] scratch_field;
        logic [7:0]  check_count;
        logic        last_frame_rejected;
        supervision_regs_pkg::pin_levels_s pin_snap;
        logic [15:0] read_data;
        logic        read_valid;
        logic        clock_check_start;
        logic        dio_check_start;
    } state_s;

    state_s      cur;
    state_s      next_cur;
    logic        hit_select;
    logic        hit_scratch;
    logic        hit_pins;
    logic        hit_count;
    logic        take_write;
    logic        write_select;
    logic        write_scratch;
    logic        start_clock;
    logic        start_dio;
    logic [6:0]  pin_bits;
    logic [15:0] select_word;
    logic [15:0] scratch_word;
    wire  [15:0] pin_word;
    logic [15:0] count_word;
    logic [15:0] raw_word;
    logic [15:0] sealed_word;

    odd_parity_word u_parity (
        .raw_word    (raw_word),
        .sealed_word (sealed_word)
    );

    // Index decode shared by the read path and the write path.
    always_comb begin
        hit_select  = 1'b0;
        hit_scratch = 1'b0;
        hit_pins    = 1'b0;
        hit_count   = 1'b0;
        if (request.index ==
            supervision_regs_pkg::offset_supervision_select) begin
            hit_select = 1'b1;
        end else if (request.index ==
                     supervision_regs_pkg::offset_scratch_value) begin
            hit_scratch = 1'b1;
        end else if (request.index ==
                     supervision_regs_pkg::offset_pin_level_snapshot) begin
            hit_pins = 1'b1;
        end else if (request.index ==
                     supervision_regs_pkg::offset_clock_check) begin
            hit_count = 1'b1;
        end
        take_write    = request.valid && request.write;
        // Only the two host fields have write enables.
        write_select  = take_write && hit_select;
        write_scratch = take_write && hit_scratch;
    end

    // Function armed by the stored choice; reserved and none arm nothing.
    always_comb begin
        start_clock = 1'b0;
        start_dio   = 1'b0;
        case (cur.verification_choice)
            supervision_regs_pkg::choice_clock: begin
                start_clock = 1'b1;
            end
            supervision_regs_pkg::choice_dio: begin
                start_dio = 1'b1;
            end
            default: begin
                start_clock = 1'b0;
                start_dio   = 1'b0;
            end
        endcase
    end

    // Pin levels placed bit by bit into their field.
    assign pin_bits = cur.pin_snap;
    for (genvar b = supervision_regs_pkg::pin_lsb;
         b <= supervision_regs_pkg::pin_msb;
         b++) begin : g_pin_field
        assign pin_word[b] = pin_bits[b - supervision_regs_pkg::pin_lsb];
    end
    assign pin_word[15:supervision_regs_pkg::pin_msb + 1] = '0;
    assign pin_word[supervision_regs_pkg::pin_lsb - 1:0]  = '0;

    always_comb begin
        select_word  = 16'h0000;
        scratch_word = 16'h0000;
        count_word   = 16'h0000;
        select_word[supervision_regs_pkg::choice_msb:
                    supervision_regs_pkg::choice_lsb] =
            cur.verification_choice;
        scratch_word[supervision_regs_pkg::scratch_msb:
                     supervision_regs_pkg::scratch_lsb] =
            cur.scratch_field;
        count_word[supervision_regs_pkg::count_msb:
                   supervision_regs_pkg::count_lsb] =
            cur.check_count;
    end

    // Unmapped indices answer an all-zero word with flag and parity.
    always_comb begin
        raw_word = 16'h0000;
        if (hit_select) begin
            raw_word = select_word;
        end else if (hit_scratch) begin
            raw_word = scratch_word;
        end else if (hit_pins) begin
            raw_word = pin_word;
        end else if (hit_count) begin
            raw_word = count_word;
        end
        raw_word[supervision_regs_pkg::rejected_bit] =
            cur.last_frame_rejected;
    end

    always_comb begin
        next_cur                   = cur;
        next_cur.read_valid        = 1'b0;
        next_cur.clock_check_start = 1'b0;
        next_cur.dio_check_start   = 1'b0;
        // Pin levels are sampled every cycle.
        next_cur.pin_snap = pins;
        if (clock_check_done) begin
            next_cur.check_count = clock_check_count;
        end
        if (request.valid) begin
            next_cur.read_valid = 1'b1;
            next_cur.read_data  = sealed_word;
        end
        if (write_select) begin
            next_cur.verification_choice =
                request.data[supervision_regs_pkg::choice_msb:
                             supervision_regs_pkg::choice_lsb];
        end
        if (write_scratch) begin
            next_cur.scratch_field =
                request.data[supervision_regs_pkg::scratch_msb:
                             supervision_regs_pkg::scratch_lsb];
        end
        if (frame_done) begin
            next_cur.last_frame_rejected = frame_rejected;
        end
        // Starts fire only on entry into the verification mode.
        if (enter_verification) begin
            next_cur.clock_check_start = start_clock;
            next_cur.dio_check_start   = start_dio;
        end
        // Entry into the initial mode wins over a same-cycle write.
        if (enter_initial) begin
            next_cur.verification_choice =
                supervision_regs_pkg::choice_none;
        end
        // Synchronous reset overrides every update above.
        if (rst) begin
            next_cur = '0;
            next_cur.verification_choice =
                supervision_regs_pkg::reset_supervision_select[
                    supervision_regs_pkg::choice_msb:
                    supervision_regs_pkg::choice_lsb];
            next_cur.scratch_field =
                supervision_regs_pkg::reset_scratch_value[
                    supervision_regs_pkg::scratch_msb:
                    supervision_regs_pkg::scratch_lsb];
            next_cur.check_count =
                supervision_regs_pkg::reset_clock_check[
                    supervision_regs_pkg::count_msb:
                    supervision_regs_pkg::count_lsb];
        end
    end

    always_ff @(posedge mclk) begin
        cur <= next_cur;
    end

    // Outputs are taken straight from the state register.
    always_comb begin
        read_data         = cur.read_data;
        read_valid        = cur.read_valid;
        clock_check_start = cur.clock_check_start;
        dio_check_start   = cur.dio_check_start;
    end

endmodule
